/* File: bench/flash_option_loader_regs_properties.sv */
// Purpose: Port checks of the option loader
// Assumes: One clock, synchronous reset
// Notes: Read valid comes 2 + wait states cycles after a request
`timescale 1ns/10ps
`default_nettype none
module flash_option_loader_regs_properties #(
    parameter logic [31:0] unlock_key2 = 32'h0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Loader and read path
    input wire logic [31:0] info_addr,
    input wire logic info_read,
    input wire logic options_loaded,
    input wire logic low_power_entry,
    input wire logic flash_abort,
    input wire logic flash_read_req,
    input wire logic flash_read_valid,
    // Configuration
    input wire logic [2:0] wait_states,
    input wire logic half_cycle_access_enable,
    input wire logic prefetch_enable,
    input wire logic controller_locked,
    input wire logic option_write_enable
);
    logic key2_write;
    wire acc_w = psel && penable && pwrite;
    wire [4:0] acr_bits = pwdata[4:0];
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            key2_write <= 1'b0;
        end else begin
            key2_write <= acc_w && paddr == 8'h04 && pwdata == unlock_key2;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////
    loader_order_a: assert property ($fell(srst) |->
        info_read && info_addr == flash_option_pkg::info_user_addr
        ##2 info_read && info_addr == flash_option_pkg::info_guard_lo_addr
        ##2 info_read && info_addr == flash_option_pkg::info_guard_hi_addr
        ##2 options_loaded) else $error("loader sequence wrong");
    unused_word_a: assert property (info_read |->
        info_addr != flash_option_pkg::info_unused_addr) else $error("unused word read");
    option_write_a: assert property (acc_w && paddr == 8'h1c |-> pslverr)
        else $error("option register write accepted");
    key_reads_zero_a: assert property (psel && penable && !pwrite &&
        (paddr == 8'h04 || paddr == 8'h08) |-> prdata == 32'h0) else $error("key read not zero");
    abort_low_power_a: assert property (low_power_entry |-> flash_abort)
        else $error("no abort in low power");
    access_fields_a: assert property (acc_w && paddr == 8'h00 |=>
        {prefetch_enable, half_cycle_access_enable, wait_states} == $past(acr_bits))
        else $error("access control fields wrong");
    read_zero_wait_a: assert property (flash_read_req && wait_states == 3'h0 |->
        ##1 !flash_read_valid ##1 flash_read_valid) else $error("zero wait timing");
    read_one_wait_a: assert property (flash_read_req && wait_states == 3'h1 |->
        ##1 !flash_read_valid [*2] ##1 flash_read_valid) else $error("one wait timing");
    read_two_wait_a: assert property (flash_read_req && wait_states == 3'h2 |->
        ##1 !flash_read_valid [*3] ##1 flash_read_valid) else $error("two wait timing");
    option_key_lock_a: assert property (acc_w && paddr == 8'h08 && controller_locked
        |=> !$rose(option_write_enable)) else $error("option unlock while locked");
    unlock_cause_a: assert property ($fell(controller_locked) |-> key2_write)
        else $error("unlock without second key");
    cover property ($rose(options_loaded));
    cover property ($fell(controller_locked));
    cover property (flash_read_valid && wait_states == 3'h2);
endmodule
`default_nettype wire

/* File: bench/flash_option_loader_regs_tb.sv */
// Purpose: Self-checking bench, option loader
// Assumes: APB tasks wait for pready
// Notes: Key values are arbitrary
`timescale 1ns/10ps
`default_nettype none
module flash_option_loader_regs_tb;
    localparam logic [31:0] key1 = 32'h13572468;
    localparam logic [31:0] key2 = 32'h8badf00d;
    logic ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, flash_read_word = 32'h0, prdata, info_addr, info_data;
    logic [31:0] flash_read_data, page_group_write_guard_bytes, rd, e;
    logic [31:0] user_word = 32'h0, guard_lo_word = 32'h0, guard_hi_word = 32'h0;
    logic [4:0] ev = 5'h0;
    logic [2:0] wait_states;
    logic prefetch_active = 1'b0, low_power_entry = 1'b0, err, pready, pslverr, info_read;
    logic flash_read_valid, flash_abort, options_loaded, readout_protect;
    logic option_mismatch_error, standby_reset_request, stop_reset_request;
    logic watchdog_software_select, half_cycle_access_enable, prefetch_enable;
    logic controller_locked, option_write_enable;
    int num_errors = 0, samples_checked = 0, i;
    wire op_start = ev[0];
    wire op_success = ev[1];
    wire op_fail = ev[2];
    wire guard_violation = ev[3];
    wire flash_read_req = ev[4];
    flash_option_loader_regs #(.unlock_key1(key1), .unlock_key2(key2))
        flash_option_loader_regs_i (.*);
    info_block_model info_block_model_i (.ref_clk, .info_addr, .info_read, .info_data,
        .user_word, .guard_lo_word, .guard_hi_word);
    ////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input string w, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(w, rd, x);
    endtask
    task automatic pulse(input int k);
        @(posedge ref_clk);
        ev[k] <= 1'b1;
        @(posedge ref_clk);
        ev[k] <= 1'b0;
    endtask
    function automatic logic [31:0] ow(input logic [7:0] b1, input logic [7:0] b0);
        return {~b1, b1, ~b0, b0};
    endfunction
    task automatic do_reset(input logic [31:0] u, input logic [31:0] lo, input logic [31:0] hi);
        int n;
        user_word <= u;
        guard_lo_word <= lo;
        guard_hi_word <= hi;
        srst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (!options_loaded && n < 20);
        check("load cycles", 32'(n), 32'h6);
    endtask
    // Options: protect, error, standby, stop, watchdog
    task automatic opts(input logic [31:0] x, input logic [31:0] g, input logic [31:0] o);
        check("options", {readout_protect, option_mismatch_error, standby_reset_request,
            stop_reset_request, watchdog_software_select}, x);
        check("guard", page_group_write_guard_bytes, g);
        rd_chk("option reg", 8'h1c, o);
        rd_chk("guard reg", 8'h20, g);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        conclude();
    end
    initial begin
        do_reset(ow(8'hfd, 8'ha5), ow(8'h3c, 8'hf0), ow(8'h0f, 8'h81));
        opts(32'h03, 32'h0f813cf0, 32'h3f4);
        apb(1'b1, 8'h1c, 32'h0);
        check("option wr err", err, 32'h1);
        rd_chk("option reg", 8'h1c, 32'h3f4);
        rd_chk("ctl key", 8'h04, 32'h0);
        rd_chk("opt key", 8'h08, 32'h0);
        rd_chk("unmapped", 8'h18, 32'h0);
        check("unmapped err", err, 32'h1);
        $display("test loader done");
        do_reset({16'hffff, 16'h00a5}, {~8'h3c, 8'h3c, 8'h12, 8'hf0}, 32'hffffffff);
        opts(32'h19, 32'hffff3cff, 32'h3ff);
        do_reset(32'hffffffff, 32'hffffffff, 32'hffffffff);
        opts(32'h11, 32'hffffffff, 32'h3fe);
        $display("test mismatch done");
        rd_chk("acr reset", 8'h00, 32'h01);
        flash_read_word <= 32'hc0de5a17;
        for (i = 0; i < 3; i++) begin
            prefetch_active <= (i == 2);
            apb(1'b1, 8'h00, 32'(32'h30 | i | (i << 3)));
            e = 32'(32'h10 | i | ((i & 1) << 3));
            check("acr ports", {prefetch_enable, half_cycle_access_enable, wait_states}, e);
            rd_chk("acr", 8'h00, e | ((i == 2) ? 32'h20 : 32'h0));
            pulse(4);
            e = 0;
            do begin
                @(posedge ref_clk);
                #1;
                e++;
            end while (!flash_read_valid && e < 20);
            check("read wait", e, 32'(i + 1));
            check("read data", flash_read_data, 32'hc0de5a17);
        end
        apb(1'b1, 8'h00, 32'h0);
        check("prefetch off", prefetch_enable, 32'h0);
        $display("test access done");
        apb(1'b1, 8'h08, key1);
        apb(1'b1, 8'h08, key2);
        check("opt we locked", option_write_enable, 32'h0);
        apb(1'b1, 8'h04, key2);
        check("lock partial", controller_locked, 32'h1);
        apb(1'b1, 8'h04, key1);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h04, key2);
        check("lock broken", controller_locked, 32'h1);
        apb(1'b1, 8'h04, key1);
        apb(1'b1, 8'h04, key2);
        check("unlock", controller_locked, 32'h0);
        apb(1'b1, 8'h08, key1);
        apb(1'b1, 8'h08, key2);
        check("opt we", option_write_enable, 32'h1);
        apb(1'b1, 8'h10, 32'h80);
        check("relock", {controller_locked, option_write_enable}, 32'h2);
        $display("test keys done");
        rd_chk("status reset", 8'h0c, 32'h0);
        pulse(0);
        rd_chk("busy", 8'h0c, 32'h1);
        pulse(1);
        rd_chk("done", 8'h0c, 32'h20);
        apb(1'b1, 8'h0c, 32'h0);
        rd_chk("done kept", 8'h0c, 32'h20);
        apb(1'b1, 8'h0c, 32'h20);
        rd_chk("done clr", 8'h0c, 32'h0);
        pulse(0);
        pulse(3);
        rd_chk("guard err", 8'h0c, 32'h10);
        apb(1'b1, 8'h0c, 32'h0);
        rd_chk("guard kept", 8'h0c, 32'h10);
        apb(1'b1, 8'h0c, 32'h10);
        rd_chk("guard clr", 8'h0c, 32'h0);
        pulse(0);
        pulse(2);
        rd_chk("fail", 8'h0c, 32'h0);
        pulse(0);
        @(posedge ref_clk);
        low_power_entry <= 1'b1;
        #1;
        check("abort", flash_abort, 32'h1);
        @(posedge ref_clk);
        low_power_entry <= 1'b0;
        rd_chk("lp busy", 8'h0c, 32'h0);
        $display("test status done");
        conclude();
    end
endmodule
bind flash_option_loader_regs flash_option_loader_regs_properties #(.unlock_key2(unlock_key2))
    props_i (.*);
`default_nettype wire

/* File: bench/info_block_model.sv */
// Purpose: Information block model
// Assumes: Requested word appears at the next edge
// Notes: Idle cycles invert the word, so stale data shows
`timescale 1ns/10ps
`default_nettype none
module info_block_model (
    // Clock
    input wire logic ref_clk,
    // Read port
    input wire logic [31:0] info_addr,
    input wire logic info_read,
    output logic [31:0] info_data,
    // Stored words
    input wire logic [31:0] user_word,
    input wire logic [31:0] guard_lo_word,
    input wire logic [31:0] guard_hi_word
);
    logic [31:0] word_q = 32'h0;
    assign info_data = word_q;
    always @(posedge ref_clk) begin
        if (info_read) begin
            case (info_addr)
                flash_option_pkg::info_user_addr: word_q <= user_word;
                flash_option_pkg::info_guard_lo_addr: word_q <= guard_lo_word;
                flash_option_pkg::info_guard_hi_addr: word_q <= guard_hi_word;
                default: word_q <= ~word_q;
            endcase
        end else begin
            word_q <= ~word_q;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/flash_option_loader_regs.sv */
// Purpose: Flash option byte loader and APB registers
// Assumes: Information block answers one cycle after a read
// Notes: Program/erase sequencing lives outside this block
//
// What this block does
// RULE1: Word: byte0, ~byte0, byte1, ~byte1
// RULE2: Read words 0x800, 0x808, 0x80c; skip 0x804
// RULE3: Readout open only with key 0xa5
// RULE4: Readout key decodes to one protect output
// RULE5: Standby reset when bit 18 is zero
// RULE6: Stop reset when bit 17 is zero
// RULE7: Watchdog software when bit 16 set
// RULE8: Each guard bit covers four 1K pages
// RULE9: Load options after every reset
// RULE10: Mismatch sets error and forces byte 0xff
// RULE11: Erased pair skips the complement check
// RULE12: True bits only; option registers read-only
// RULE13: Abort flash access on low-power entry
// RULE14: Latency codes give zero, one, two waits
// RULE15: Bit4 prefetch enable, bit5 prefetch state
// RULE16: Bit3 enables half-cycle access
// RULE17: Controller key write-only, reads zero
// RULE18: Option key sequence sets write enable
// RULE19: Done flag set at end, write-one clears
// RULE20: Guard error set on protected target
// RULE21: Guard error clears only by writing one
// RULE22: Busy from start to finish
// RULE23: Wrong or partial key keeps lock
// RULE24: Read path inserts selected wait states
`timescale 1ns/10ps
`default_nettype none
module flash_option_loader_regs #(
    parameter logic [31:0] unlock_key1 = 32'h01234567,
    parameter logic [31:0] unlock_key2 = 32'h89abcdef
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Information block read port
    output logic [31:0] info_addr,
    output logic info_read,
    input wire logic [31:0] info_data,
    // Operation links from program/erase controller
    input wire logic op_start,
    input wire logic op_success,
    input wire logic op_fail,
    input wire logic guard_violation,
    input wire logic prefetch_active,
    input wire logic low_power_entry,
    // Flash read path
    input wire logic flash_read_req,
    input wire logic [31:0] flash_read_word,
    output logic flash_read_valid,
    output logic [31:0] flash_read_data,
    output logic flash_abort,
    // Published configuration
    output logic options_loaded,
    output logic readout_protect,
    output logic option_mismatch_error,
    output logic standby_reset_request,
    output logic stop_reset_request,
    output logic watchdog_software_select,
    output logic [31:0] page_group_write_guard_bytes,
    output logic [2:0] wait_states,
    output logic half_cycle_access_enable,
    output logic prefetch_enable,
    output logic controller_locked,
    output logic option_write_enable
);

    ////////////////////////////////////////////////////////////////////////
    // Option byte check: returns checked byte, bit 8 flags a mismatch

    function automatic logic [8:0] check_byte(input logic [7:0] value, input logic [7:0] inverse);
        logic [8:0] result;
        result = {1'b0, value};
        if (&{value, inverse}) begin
            result = {1'b0, value}; // [RULE11]
        end else if (value != ~inverse) begin
            result = {1'b1, flash_option_pkg::erased_byte}; // [RULE10]
        end
        return result;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Loader

    flash_option_pkg::loader_state_type state;
    logic [7:0] readout_protect_byte;
    logic [7:0] user_byte;
    logic [8:0] chk0;
    logic [8:0] chk1;
    logic [8:0] chk2;
    logic [8:0] chk3;
    logic wait_data;

    // Information block word layout: byte0, ~byte0, byte1, ~byte1 [RULE1]
    assign chk0 = check_byte(info_data[7:0], info_data[15:8]);
    assign chk1 = check_byte(info_data[23:16], info_data[31:24]);
    assign chk2 = chk0;
    assign chk3 = chk1;

    always_comb begin
        case (state)
            flash_option_pkg::load_user: info_addr = flash_option_pkg::info_user_addr; // [RULE2]
            flash_option_pkg::load_guard_lo: info_addr = flash_option_pkg::info_guard_lo_addr;
            flash_option_pkg::load_guard_hi: info_addr = flash_option_pkg::info_guard_hi_addr;
            default: info_addr = flash_option_pkg::info_unused_addr;
        endcase
    end
    assign info_read = (state != flash_option_pkg::load_done) && !wait_data;

    // Read one cycle, capture the next
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= flash_option_pkg::load_user;
            wait_data <= 1'b0;
            readout_protect_byte <= flash_option_pkg::erased_byte;
            user_byte <= flash_option_pkg::erased_byte;
            page_group_write_guard_bytes <= 32'hffffffff;
            option_mismatch_error <= 1'b0;
            options_loaded <= 1'b0;
        end else if (state != flash_option_pkg::load_done) begin
            wait_data <= !wait_data;
            if (wait_data) begin
                option_mismatch_error <= option_mismatch_error | chk0[8] | chk1[8]; // [RULE10]
                case (state)
                    flash_option_pkg::load_user: begin
                        readout_protect_byte <= chk0[7:0];
                        user_byte <= chk1[7:0];
                        state <= flash_option_pkg::load_guard_lo; // [RULE2]
                    end
                    flash_option_pkg::load_guard_lo: begin
                        page_group_write_guard_bytes[15:0] <= {chk1[7:0], chk0[7:0]};
                        state <= flash_option_pkg::load_guard_hi;
                    end
                    flash_option_pkg::load_guard_hi: begin
                        page_group_write_guard_bytes[31:16] <= {chk3[7:0], chk2[7:0]};
                        state <= flash_option_pkg::load_done;
                        options_loaded <= 1'b1; // [RULE9]
                    end
                    default: state <= flash_option_pkg::load_done;
                endcase
            end
        end
    end

    // True bits only; guard bit n covers pages 4n..4n+3 [RULE8] [RULE12]
    assign readout_protect = (readout_protect_byte != flash_option_pkg::readout_open_key); // [RULE3] [RULE4]
    assign standby_reset_request = !user_byte[flash_option_pkg::standby_disable_bit]; // [RULE5]
    assign stop_reset_request = !user_byte[flash_option_pkg::stop_disable_bit]; // [RULE6]
    assign watchdog_software_select = user_byte[flash_option_pkg::watchdog_sw_bit]; // [RULE7]

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    logic wr_en;
    logic rd_en;
    logic known_addr;
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign known_addr = paddr inside {flash_option_pkg::access_control_off,
        flash_option_pkg::controller_unlock_key_off,
        flash_option_pkg::option_unlock_key_off,
        flash_option_pkg::operation_status_off,
        flash_option_pkg::lock_control_off,
        flash_option_pkg::option_byte_off,
        flash_option_pkg::write_guard_off};
    // Option registers are read-only: writes to them are refused [RULE12]
    assign pslverr = psel && penable && (!known_addr || (pwrite
        && (paddr == flash_option_pkg::option_byte_off
        || paddr == flash_option_pkg::write_guard_off)));

    ////////////////////////////////////////////////////////////////////////
    // Access control

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wait_states <= flash_option_pkg::latency_reset;
            half_cycle_access_enable <= 1'b0;
            prefetch_enable <= 1'b0;
        end else if (wr_en && paddr == flash_option_pkg::access_control_off) begin
            wait_states <= pwdata[flash_option_pkg::latency_lsb +: 3]; // [RULE14]
            half_cycle_access_enable <= pwdata[flash_option_pkg::half_cycle_bit]; // [RULE16]
            prefetch_enable <= pwdata[flash_option_pkg::prefetch_enable_bit]; // [RULE15]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Key sequences: first key arms, second key must be the next write to that key register

    logic controller_armed;
    logic option_armed;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            controller_locked <= 1'b1;
            controller_armed <= 1'b0;
        end else if (wr_en && paddr == flash_option_pkg::controller_unlock_key_off) begin
            controller_armed <= (pwdata == unlock_key1); // [RULE23]
            if (controller_armed && pwdata == unlock_key2) begin
                controller_locked <= 1'b0; // [RULE17]
            end
        end else if (wr_en && paddr == flash_option_pkg::lock_control_off
                     && pwdata[flash_option_pkg::controller_lock_bit]) begin
            controller_locked <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            option_write_enable <= 1'b0;
            option_armed <= 1'b0;
        end else if (wr_en && paddr == flash_option_pkg::option_unlock_key_off) begin
            option_armed <= (pwdata == unlock_key1); // [RULE23]
            if (option_armed && pwdata == unlock_key2 && !controller_locked) begin
                option_write_enable <= 1'b1; // [RULE18]
            end
        end else if (wr_en && paddr == flash_option_pkg::lock_control_off
                     && !pwdata[flash_option_pkg::option_write_bit]) begin
            option_write_enable <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags: hardware set wins over software clear

    logic busy;
    logic guard_error;
    logic done_flag;
    logic status_wr;
    assign status_wr = wr_en && paddr == flash_option_pkg::operation_status_off;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy <= 1'b0;
        end else if (op_start) begin
            busy <= 1'b1; // [RULE22]
        end else if (op_success || op_fail || guard_violation || low_power_entry) begin
            busy <= 1'b0; // [RULE22]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            done_flag <= 1'b0;
        end else if (op_success) begin
            done_flag <= 1'b1; // [RULE19]
        end else if (status_wr && pwdata[flash_option_pkg::done_bit]) begin
            done_flag <= 1'b0; // [RULE19]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            guard_error <= 1'b0;
        end else if (guard_violation) begin
            guard_error <= 1'b1; // [RULE20]
        end else if (status_wr && pwdata[flash_option_pkg::guard_error_bit]) begin
            guard_error <= 1'b0; // [RULE21]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flash read path with wait states; aborted on low-power entry

    logic [2:0] wait_count;
    logic read_pending;
    assign flash_abort = low_power_entry && (read_pending || busy); // [RULE13]

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            read_pending <= 1'b0;
            wait_count <= 3'h0;
            flash_read_valid <= 1'b0;
            flash_read_data <= 32'h00000000;
        end else begin
            flash_read_valid <= 1'b0;
            if (low_power_entry) begin
                read_pending <= 1'b0; // [RULE13]
            end else if (read_pending) begin
                if (wait_count == 3'h0) begin
                    read_pending <= 1'b0;
                    flash_read_valid <= 1'b1;
                    flash_read_data <= flash_read_word;
                end else begin
                    wait_count <= wait_count - 3'h1; // [RULE24]
                end
            end else if (flash_read_req) begin
                read_pending <= 1'b1;
                wait_count <= wait_states; // [RULE14] [RULE24]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h00000000;
            case (paddr)
                flash_option_pkg::access_control_off: begin
                    prdata[flash_option_pkg::latency_lsb +: 3] <= wait_states;
                    prdata[flash_option_pkg::half_cycle_bit] <= half_cycle_access_enable;
                    prdata[flash_option_pkg::prefetch_enable_bit] <= prefetch_enable;
                    prdata[flash_option_pkg::prefetch_state_bit] <= prefetch_active; // [RULE15]
                end
                flash_option_pkg::operation_status_off: begin
                    prdata[flash_option_pkg::busy_bit] <= busy;
                    prdata[flash_option_pkg::guard_error_bit] <= guard_error;
                    prdata[flash_option_pkg::done_bit] <= done_flag;
                end
                flash_option_pkg::lock_control_off: begin
                    prdata[flash_option_pkg::controller_lock_bit] <= controller_locked;
                    prdata[flash_option_pkg::option_write_bit] <= option_write_enable;
                end
                flash_option_pkg::option_byte_off: begin
                    prdata[9:0] <= {user_byte, readout_protect, option_mismatch_error};
                end
                flash_option_pkg::write_guard_off: begin
                    prdata <= page_group_write_guard_bytes;
                end
                // Key registers read as zero [RULE17] [RULE18]
                default: prdata <= 32'h00000000;
            endcase
        end
    end

endmodule
`default_nettype wire

/* File: verilog/flash_option_pkg.sv */
// Purpose: Constants of the flash option loader
// Assumes: APB with 32-bit data, byte addresses
// Notes: Key values are top-level parameters
package flash_option_pkg;
    // Register byte offsets
    localparam logic [7:0] access_control_off = 8'h00;
    localparam logic [7:0] controller_unlock_key_off = 8'h04;
    localparam logic [7:0] option_unlock_key_off = 8'h08;
    localparam logic [7:0] operation_status_off = 8'h0c;
    localparam logic [7:0] lock_control_off = 8'h10;
    localparam logic [7:0] option_byte_off = 8'h1c;
    localparam logic [7:0] write_guard_off = 8'h20;
    // Information block word addresses
    localparam logic [31:0] info_user_addr = 32'h1ffff800;
    localparam logic [31:0] info_unused_addr = 32'h1ffff804;
    localparam logic [31:0] info_guard_lo_addr = 32'h1ffff808;
    localparam logic [31:0] info_guard_hi_addr = 32'h1ffff80c;
    // Option values
    localparam logic [7:0] readout_open_key = 8'ha5;
    localparam logic [7:0] erased_byte = 8'hff;
    // Access control fields
    localparam int latency_lsb = 0;
    localparam int half_cycle_bit = 3;
    localparam int prefetch_enable_bit = 4;
    localparam int prefetch_state_bit = 5;
    localparam logic [2:0] latency_reset = 3'h1;
    // Status fields
    localparam int busy_bit = 0;
    localparam int guard_error_bit = 4;
    localparam int done_bit = 5;
    // Lock control fields
    localparam int controller_lock_bit = 7;
    localparam int option_write_bit = 9;
    // User byte fields
    localparam int watchdog_sw_bit = 0;
    localparam int stop_disable_bit = 1;
    localparam int standby_disable_bit = 2;
    typedef enum logic [2:0] {
        load_user = 3'b000,
        load_guard_lo = 3'b001,
        load_guard_hi = 3'b010,
        load_done = 3'b011
    } loader_state_type;
endpackage
